/* tpc_pkg.sv */
package tpc_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_AMODE = 8'h04;
  localparam logic [7:0] ADDR_BMODE = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam int ADDR_W = 8;

  // Control register field positions
  localparam int CTL_A_RUN = 0;
  localparam int CTL_A_FREEZE = 1;
  localparam int CTL_A_EDGE_LO = 2;
  localparam int CTL_RTC_EN = 4;
  localparam int CTL_A_PWM_INV = 6;
  localparam int CTL_B_RUN = 8;
  localparam int CTL_B_FREEZE = 9;
  localparam int CTL_W = 10;
  localparam logic [CTL_W-1:0] CTL_WMASK = 10'h35f;
  localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;

  // Configuration and mode field widths
  localparam int CFG_W = 3;
  localparam int MODE_W = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic [CFG_W-1:0] CFG_FULL_WIDTH = 3'h0;
  localparam logic [CFG_W-1:0] CFG_RTC = 3'h1;
  localparam logic [1:0] MR_CAPTURE = 2'h3;
  localparam int MR_AMS = 3;

  // Edge select encodings
  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_RSVD = 2'h2,
    EDGE_BOTH = 2'h3
  } tpc_edge_t;

  // Software-visible control bits
  typedef struct packed {
    logic halfBDebugFreeze;
    logic halfBRun;
    logic halfAPwmInvert;
    logic rtcCountEnable;
    tpc_edge_t halfAEdgeSelect;
    logic halfADebugFreeze;
    logic halfARun;
  } tpc_ctrl_t;

  // Per-half steering delivered to the datapath
  typedef struct packed {
    logic countEn;
    logic captureEn;
    logic frozen;
  } tpc_half_t;

  // Wishbone request group
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
  } tpc_wbreq_t;

endpackage : tpc_pkg

/* tpc_sync.sv */
`timescale 1ns/1ns
// Two-stage synchroniser for an asynchronous level
module tpc_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Level in and out
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic meta;
    logic sync;
  } tpc_sync_t;

  tpc_sync_t state_q;
  tpc_sync_t state_d;

  // Shift the level through two flops
  always_comb begin
    state_d = state_q;
    state_d.meta = din;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign dout = state_q.sync;

endmodule : tpc_sync

/* tpc_half_gate.sv */
`timescale 1ns/1ns
// Decides count or capture for one timer half
module tpc_half_gate (
  // Control inputs
  input wire logic run,
  input wire logic freezeOnHalt,
  input wire logic debugHalt,
  input wire logic [tpc_pkg::CFG_W-1:0] cfg,
  input wire logic [tpc_pkg::MODE_W-1:0] mode,
  // Steering out
  output tpc_pkg::tpc_half_t steer
);

  logic isCapture;

  // Capture only in split mode with capture mode and not PWM
  always_comb begin
    isCapture = (cfg != tpc_pkg::CFG_FULL_WIDTH) && (cfg != tpc_pkg::CFG_RTC)
      && (mode[1:0] == tpc_pkg::MR_CAPTURE) && !mode[tpc_pkg::MR_AMS];
    steer.frozen = run && freezeOnHalt && debugHalt;
    steer.countEn = run && !isCapture && !steer.frozen;
    steer.captureEn = run && isCapture && !steer.frozen;
  end

endmodule : tpc_half_gate

/* timer_pair_control_bits.sv */
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Half B freezes under debug halt when its freeze bit is set.
// - Half B run bit starts counting or capture per configuration; clear disables.
// - Half A PWM output is inverted when the invert bit is one.
// - RTC counting runs only while its enable bit is one.
// - Half A edge select: 0 rising, 1 falling, 3 both; 2 reserved.
// - Half A freezes under debug halt when its freeze bit is set.
// - Half A run bit starts counting or capture per configuration; clear disables.
// - Count versus capture follows configuration bits 2:0 and the half mode.
module timer_pair_control_bits (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [tpc_pkg::ADDR_W-1:0] wbAdr,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Processor debug state (asynchronous)
  input wire logic debugHalt,
  // Raw PWM and capture input from the datapath
  input wire logic halfAPwmRaw,
  input wire logic halfACapIn,
  // Steering outputs
  output logic halfACountEn,
  output logic halfACaptureEn,
  output logic halfBCountEn,
  output logic halfBCaptureEn,
  output logic rtcCountEn,
  output logic halfAPwmOut,
  output logic halfACapEvent
);

  typedef struct packed {
    tpc_pkg::tpc_ctrl_t ctrl;
    logic [tpc_pkg::CFG_W-1:0] cfg;
    logic [tpc_pkg::MODE_W-1:0] modeA;
    logic [tpc_pkg::MODE_W-1:0] modeB;
    logic ack;
    logic [31:0] rdata;
    logic capPrev;
    tpc_pkg::tpc_half_t steerA;
    tpc_pkg::tpc_half_t steerB;
    logic rtcRun;
    logic pwmOut;
    logic capEvent;
  } tpc_state_t;

  tpc_state_t state_q;
  tpc_state_t state_d;
  tpc_pkg::tpc_wbreq_t req;
  tpc_pkg::tpc_half_t gateA;
  tpc_pkg::tpc_half_t gateB;
  logic haltSync;
  logic capSync;
  logic pwmSync;
  logic [tpc_pkg::CTL_W-1:0] ctlWord;
  logic [tpc_pkg::CTL_W-1:0] ctlNew;
  logic [31:0] ctlMerged;

  // Merge byte lanes of a write into an old word
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  // Edge detection per selected mode
  function automatic logic edgeHit(input tpc_pkg::tpc_edge_t sel, input logic prev,
                                   input logic cur);
    logic hit;
    case (sel)
      tpc_pkg::EDGE_RISE: hit = !prev && cur;
      tpc_pkg::EDGE_FALL: hit = prev && !cur;
      tpc_pkg::EDGE_BOTH: hit = prev ^ cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edgeHit

  // Synchronise asynchronous inputs
  tpc_sync u_haltSync (
    .mclk(mclk),
    .resetn(resetn),
    .din(debugHalt),
    .dout(haltSync)
  );

  tpc_sync u_capSync (
    .mclk(mclk),
    .resetn(resetn),
    .din(halfACapIn),
    .dout(capSync)
  );

  tpc_sync u_pwmSync (
    .mclk(mclk),
    .resetn(resetn),
    .din(halfAPwmRaw),
    .dout(pwmSync)
  );

  // Count or capture steering per half
  tpc_half_gate u_gateA (
    .run(state_q.ctrl.halfARun),
    .freezeOnHalt(state_q.ctrl.halfADebugFreeze),
    .debugHalt(haltSync),
    .cfg(state_q.cfg),
    .mode(state_q.modeA),
    .steer(gateA)
  );

  tpc_half_gate u_gateB (
    .run(state_q.ctrl.halfBRun),
    .freezeOnHalt(state_q.ctrl.halfBDebugFreeze),
    .debugHalt(haltSync),
    .cfg(state_q.cfg),
    .mode(state_q.modeB),
    .steer(gateB)
  );

  // Bundle the bus request
  always_comb begin
    req.cyc = wbCyc;
    req.stb = wbStb;
    req.we = wbWe;
    req.sel = wbSel;
    req.adr = wbAdr;
    req.dat = wbDatW;
  end

  // Control word view with reserved bits held at zero
  always_comb begin
    ctlWord = '0;
    ctlWord[tpc_pkg::CTL_A_RUN] = state_q.ctrl.halfARun;
    ctlWord[tpc_pkg::CTL_A_FREEZE] = state_q.ctrl.halfADebugFreeze;
    ctlWord[tpc_pkg::CTL_A_EDGE_LO +: 2] = state_q.ctrl.halfAEdgeSelect;
    ctlWord[tpc_pkg::CTL_RTC_EN] = state_q.ctrl.rtcCountEnable;
    ctlWord[tpc_pkg::CTL_A_PWM_INV] = state_q.ctrl.halfAPwmInvert;
    ctlWord[tpc_pkg::CTL_B_RUN] = state_q.ctrl.halfBRun;
    ctlWord[tpc_pkg::CTL_B_FREEZE] = state_q.ctrl.halfBDebugFreeze;
    // Merge first, then keep only the writable bits
    ctlMerged = laneMerge({22'h0, ctlWord}, req.dat, req.sel);
    ctlNew = ctlMerged[tpc_pkg::CTL_W-1:0] & tpc_pkg::CTL_WMASK;
  end

  // Next state: bus slave, register writes, output stage
  always_comb begin
    logic [31:0] tmp;
    logic access;
    tmp = '0;
    state_d = state_q;
    access = req.cyc && req.stb && !state_q.ack;
    state_d.ack = access;
    state_d.rdata = '0;
    if (access && req.we) begin
      case (req.adr)
        tpc_pkg::ADDR_CTRL: begin
          state_d.ctrl.halfARun = ctlNew[tpc_pkg::CTL_A_RUN];
          state_d.ctrl.halfADebugFreeze = ctlNew[tpc_pkg::CTL_A_FREEZE];
          state_d.ctrl.halfAEdgeSelect =
            tpc_pkg::tpc_edge_t'(ctlNew[tpc_pkg::CTL_A_EDGE_LO +: 2]);
          state_d.ctrl.rtcCountEnable = ctlNew[tpc_pkg::CTL_RTC_EN];
          state_d.ctrl.halfAPwmInvert = ctlNew[tpc_pkg::CTL_A_PWM_INV];
          state_d.ctrl.halfBRun = ctlNew[tpc_pkg::CTL_B_RUN];
          state_d.ctrl.halfBDebugFreeze = ctlNew[tpc_pkg::CTL_B_FREEZE];
        end
        tpc_pkg::ADDR_CFG: begin
          tmp = laneMerge({29'h0, state_q.cfg}, req.dat, req.sel);
          state_d.cfg = tmp[tpc_pkg::CFG_W-1:0];
        end
        tpc_pkg::ADDR_AMODE: begin
          tmp = laneMerge({28'h0, state_q.modeA}, req.dat, req.sel);
          state_d.modeA = tmp[tpc_pkg::MODE_W-1:0];
        end
        tpc_pkg::ADDR_BMODE: begin
          tmp = laneMerge({28'h0, state_q.modeB}, req.dat, req.sel);
          state_d.modeB = tmp[tpc_pkg::MODE_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (access && !req.we) begin
      case (req.adr)
        tpc_pkg::ADDR_CTRL: state_d.rdata = {22'h0, ctlWord};
        tpc_pkg::ADDR_CFG: state_d.rdata = {29'h0, state_q.cfg};
        tpc_pkg::ADDR_AMODE: state_d.rdata = {28'h0, state_q.modeA};
        tpc_pkg::ADDR_BMODE: state_d.rdata = {28'h0, state_q.modeB};
        tpc_pkg::ADDR_STAT: state_d.rdata = {24'h0, haltSync, state_q.rtcRun,
                                             state_q.steerB, state_q.steerA};
        default: state_d.rdata = '0;
      endcase
    end
    // Output stage
    state_d.steerA = gateA;
    state_d.steerB = gateB;
    state_d.rtcRun = state_q.ctrl.rtcCountEnable;
    state_d.pwmOut = pwmSync ^ state_q.ctrl.halfAPwmInvert;
    state_d.capPrev = capSync;
    state_d.capEvent = gateA.captureEn &&
      edgeHit(state_q.ctrl.halfAEdgeSelect, state_q.capPrev, capSync);
  end

  // State register; everything clears on reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign wbAck = state_q.ack;
  assign wbDatR = state_q.rdata;
  assign halfACountEn = state_q.steerA.countEn;
  assign halfACaptureEn = state_q.steerA.captureEn;
  assign halfBCountEn = state_q.steerB.countEn;
  assign halfBCaptureEn = state_q.steerB.captureEn;
  assign rtcCountEn = state_q.rtcRun;
  assign halfAPwmOut = state_q.pwmOut;
  assign halfACapEvent = state_q.capEvent;

endmodule : timer_pair_control_bits

/* tpc_ctl_asserts.sv */
`timescale 1ns/1ns
// Port-level checks for the control bits
module tpc_ctl_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [tpc_pkg::ADDR_W-1:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  // Side inputs
  input wire logic debugHalt,
  input wire logic halfAPwmRaw,
  // Steering
  input wire logic halfACountEn,
  input wire logic halfACaptureEn,
  input wire logic halfBCountEn,
  input wire logic halfBCaptureEn,
  input wire logic rtcCountEn,
  input wire logic halfAPwmOut
);
  logic [9:0] shCtl_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Shadow of the control register from taken writes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shCtl_q <= 10'h000;
    end else if (wbCyc && wbStb && !wbAck && wbWe && wbAdr == tpc_pkg::ADDR_CTRL) begin
      if (wbSel[0]) shCtl_q[7:0] <= wbDatW[7:0] & 8'h5f;
      if (wbSel[1]) shCtl_q[9:8] <= wbDatW[9:8];
    end
  end
  property p_ackNext; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack late");
  property p_ackPulse; wbAck |=> !wbAck; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack held");
  property p_ctlRead; wbAck && !wbWe && wbAdr == tpc_pkg::ADDR_CTRL |-> wbDatR == {22'h000000, shCtl_q}; endproperty
  a_ctlRead: assert property (p_ctlRead) else $error("ctrl read");
  property p_aOff; !shCtl_q[0] |=> !halfACountEn && !halfACaptureEn; endproperty
  a_aOff: assert property (p_aOff) else $error("half A on");
  property p_bOff; !shCtl_q[8] |=> !halfBCountEn && !halfBCaptureEn; endproperty
  a_bOff: assert property (p_bOff) else $error("half B on");
  property p_rtc; 1'b1 |=> rtcCountEn == $past(shCtl_q[4]); endproperty
  a_rtc: assert property (p_rtc) else $error("rtc enable");
  property p_pwm; 1'b1 |=> halfAPwmOut == ($past(halfAPwmRaw, 3) ^ $past(shCtl_q[6])); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level");
  property p_frzA; (shCtl_q[1] && debugHalt) [*3] |=> !halfACountEn && !halfACaptureEn; endproperty
  a_frzA: assert property (p_frzA) else $error("half A not frozen");
  property p_frzB; (shCtl_q[9] && debugHalt) [*3] |=> !halfBCountEn && !halfBCaptureEn; endproperty
  a_frzB: assert property (p_frzB) else $error("half B not frozen");
  property p_runA; (shCtl_q[0] && !debugHalt) [*3] |=> halfACountEn || halfACaptureEn; endproperty
  a_runA: assert property (p_runA) else $error("half A idle");
  // Main scenarios reached
  c_write: cover property (wbAck && wbWe);
  c_capture: cover property (halfACaptureEn);
  c_freeze: cover property (debugHalt && shCtl_q[1] && halfBCountEn);
endmodule : tpc_ctl_asserts

bind timer_pair_control_bits tpc_ctl_asserts u_chk (.mclk(mclk), .resetn(resetn),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr),
  .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .debugHalt(debugHalt),
  .halfAPwmRaw(halfAPwmRaw), .halfACountEn(halfACountEn), .halfACaptureEn(halfACaptureEn),
  .halfBCountEn(halfBCountEn), .halfBCaptureEn(halfBCaptureEn),
  .rtcCountEn(rtcCountEn), .halfAPwmOut(halfAPwmOut));

/* tpc_core_model.sv */
`timescale 1ns/1ns
// Processor-side model: debug halt and raw timer pins
module tpc_core_model (
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire logic haltReq,
  input wire logic [1:0] pinReq,
  // Levels toward the block
  output logic debugHalt = 1'b0,
  output logic halfAPwmRaw = 1'b0,
  output logic halfACapIn = 1'b0
);
  // Levels move one edge after the request
  always @(posedge mclk) begin
    debugHalt <= haltReq;
    halfAPwmRaw <= pinReq[0];
    halfACapIn <= pinReq[1];
  end
endmodule : tpc_core_model

/* tb_timer_pair_control_bits.sv */
`timescale 1ns/1ns
// Self-checking bench for the timer control bits
module tb_timer_pair_control_bits;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic haltReq = 1'b0;
  logic [1:0] pinReq = 2'h0;
  tpc_pkg::tpc_wbreq_t req = '0;
  logic [31:0] wbDatR, rd;
  logic wbAck, debugHalt, pwmRaw, capIn, aCnt, aCap, bCnt, bCap, rtc_count_enable, pwmOut, capEv;
  int n_mismatch = 0;
  int total_checks = 0;
  int ctl, cfg, mA, mB, ev;
  logic [7:0] adrs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};

  always #10 mclk = ~mclk;

  // Design and processor model
  timer_pair_control_bits dut_u (.mclk(mclk), .resetn(resetn), .wbCyc(req.cyc),
    .wbStb(req.stb), .wbWe(req.we), .wbSel(req.sel), .wbAdr(req.adr), .wbDatW(req.dat),
    .wbDatR(wbDatR), .wbAck(wbAck), .debugHalt(debugHalt), .halfAPwmRaw(pwmRaw),
    .halfACapIn(capIn), .halfACountEn(aCnt), .halfACaptureEn(aCap), .halfBCountEn(bCnt),
    .halfBCaptureEn(bCap), .rtcCountEn(rtc_count_enable), .halfAPwmOut(pwmOut), .halfACapEvent(capEv));
  tpc_core_model u_core (.mclk(mclk), .haltReq(haltReq), .pinReq(pinReq),
    .debugHalt(debugHalt), .halfAPwmRaw(pwmRaw), .halfACapIn(capIn));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One classic cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do @(posedge mclk); while (wbAck !== 1'b1);
    rd = wbDatR;
    req <= '0;
    @(posedge mclk);
  endtask : wb

  // Steering expected from the model registers
  task automatic check_steer(input int halt);
    int capA, capB, onA, onB;
    capA = cfg > 1 && mA % 4 == 3 && mA < 8;
    capB = cfg > 1 && mB % 4 == 3 && mB < 8;
    onA = ctl[0] && !(halt && ctl[1]);
    onB = ctl[8] && !(halt && ctl[9]);
    check("aCnt", aCnt, onA && !capA);
    check("aCap", aCap, onA && capA);
    check("bCnt", bCnt, onB && !capB);
    check("bCap", bCap, onB && capB);
    check("rtc_count_enable", rtc_count_enable, ctl[4]);
  endtask : check_steer

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    void'($urandom(62602));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    ctl = 0;
    // Reset values and unmapped place
    foreach (adrs[i]) begin
      wb(1'b0, adrs[i], 32'h0);
      check("reset", rd, 0);
    end
    check_steer(0);
    // Random setups, reserved bits kept clear
    repeat (12) begin
      cfg = $urandom % 8;
      mA = $urandom % 16;
      mB = $urandom % 16;
      ctl = $urandom & 'h35f;
      wb(1'b1, tpc_pkg::ADDR_CFG, cfg);
      wb(1'b1, tpc_pkg::ADDR_AMODE, mA);
      wb(1'b1, tpc_pkg::ADDR_BMODE, mB);
      wb(1'b1, tpc_pkg::ADDR_CTRL, ctl);
      wb(1'b0, tpc_pkg::ADDR_CTRL, 32'h0);
      check("ctrl", rd, ctl);
      check_steer(0);
    end
    // Debug halt with half A freeze bit set, then both freeze bits set with halt released
    for (int i = 0; i < 3; i++) begin
      ctl = i == 2 ? 'h303 : 'h103;
      haltReq <= i < 2;
      wb(1'b1, tpc_pkg::ADDR_CTRL, ctl);
      repeat (6) @(posedge mclk);
      check_steer(i < 2);
    end
    // Output polarity against raw level
    for (int i = 0; i < 4; i++) begin
      ctl = (i % 2) * 'h40;
      pinReq[0] <= i[1];
      wb(1'b1, tpc_pkg::ADDR_CTRL, ctl);
      repeat (6) @(posedge mclk);
      check("pwmOut", pwmOut, i[1] ^ i[0]);
    end
    // Every edge code on a rise then a fall
    cfg = 4;
    mA = 3;
    wb(1'b1, tpc_pkg::ADDR_CFG, cfg);
    wb(1'b1, tpc_pkg::ADDR_AMODE, mA);
    for (int e = 0; e < 4; e++) begin
      wb(1'b1, tpc_pkg::ADDR_CTRL, 1 + e * 4);
      ev = 0;
      repeat (2) begin
        pinReq[1] <= ~pinReq[1];
        repeat (8) begin
          @(posedge mclk);
          ev += capEv;
        end
      end
      check("capCount", ev, e == 2 ? 0 : e == 3 ? 2 : 1);
    end
    stop_test();
  end
endmodule : tb_timer_pair_control_bits
